/* File: sshx_byte_counter.v */
// byte position counter framing one fixed-length report
`timescale 1ns/1ns
module sshx_byte_counter #(
    parameter LEN = 64
) (
    clk,
    rst_n,
    step,
    pos,
    last
);
    input  wire       clk;
    input  wire       rst_n;
    input  wire       step;
    output wire [5:0] pos;
    output wire       last;

    reg  [5:0] pos_ff;
    wire [5:0] nxt_pos;

    assign last    = (pos_ff == LEN[5:0] - 6'h01);
    assign nxt_pos = step ? (last ? 6'h00 : pos_ff + 6'h01) : pos_ff;
    assign pos     = pos_ff;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pos_ff <= 6'h00;
        end else begin
            pos_ff <= nxt_pos;
        end
    end
endmodule // sshx_byte_counter

/* File: sshx_consts.vh */
// constants of the settings store and hid report exchange
`ifndef SSHX_CONSTS_VH
`define SSHX_CONSTS_VH

`define SSHX_REPORT_LEN      7'h40
`define SSHX_NV_DEPTH        32
`define SSHX_VOL_DEPTH       16
`define SSHX_USB_BASE        5'h10
`define SSHX_SER_EN_ADDR     5'h10
`define SSHX_SER_NUM_ADDR    5'h11
`define SSHX_SER_NUM_LEN     8
`define SSHX_LOCK_ADDR       5'h0F
`define SSHX_LOCK_OPEN       8'h00

`define SSHX_CMD_STATUS      8'h10
`define SSHX_CMD_READ_NV     8'hB0
`define SSHX_CMD_WRITE_NV    8'hB1
`define SSHX_CMD_WRITE_VOL   8'h60
`define SSHX_CMD_READ_VOL    8'h61

`define SSHX_ST_OK           8'h00
`define SSHX_ST_REFUSED      8'h01
`define SSHX_ST_BAD_CMD      8'h02
`define SSHX_ST_BAD_ADDR     8'h03

`define SSHX_IDX_CMD         6'h00
`define SSHX_IDX_ADDR        6'h01
`define SSHX_IDX_DATA        6'h02
`define SSHX_IDX_STATUS      6'h01
`define SSHX_IDX_RDATA       6'h02
`define SSHX_IDX_LOADED      6'h03
`define SSHX_IDX_SER_EN      6'h04

`define SSHX_BYTE_ZERO       8'h00
`endif

/* File: sshx_host_model.sv */
// host model: writes command reports and reads response reports
`timescale 1ns/1ns
module sshx_host_model (
    input wire logic       clk,
    output logic           rxValid,
    output logic [7:0]     rxData,
    input wire logic       rxReady_ff,
    input wire logic       txValid_ff,
    input wire logic [7:0] txData_ff,
    output logic           txReady
);
    logic [7:0] resp [64];
    initial begin
        rxValid = 1'b0;
        rxData = 8'h00;
        txReady = 1'b0;
    end
    // called at a falling edge; each byte waits for ready at that edge
    task automatic send(input logic [7:0] cmd, addr, data);
        for (int i = 0; i < 64; i++) begin
            rxData = i == 0 ? cmd : i == 1 ? addr : i == 2 ? data : 8'(i * 37);
            rxValid = 1'b1;
            while (!rxReady_ff) @(negedge clk);
            @(negedge clk);
        end
        rxValid = 1'b0;
        // released bus must not look like a valid stale byte
        rxData = ~rxData;
    endtask
    task automatic fetch(input bit slow);
        int n = 0;
        for (int k = 0; n < 64; k++) begin
            txReady = !slow || k[0];
            if (txValid_ff && txReady) begin
                resp[n] = txData_ff;
                n++;
            end
            @(negedge clk);
        end
        txReady = 1'b0;
    endtask
endmodule // sshx_host_model

/* File: sshx_settings_store.v */
// settings store: power-up copy, protected access, 64-byte hid exchange
// Summary of operation
// - at power-up the stored settings are copied from nonvolatile storage into a volatile working copy.
// - after that copy completes, the volatile settings may be changed by hid commands.
// - both the nonvolatile and the volatile copies can be read and written through the one hid command path.
// - the store handles loading, changes and protection, and refuses writes that the lock forbids.
// - the usb-related settings are not copied into the volatile copy and are used straight from nonvolatile storage.
// - as shipped, serial-number presentation is disabled so no serial number is reported.
// - a unique preset serial number is held and the host may overwrite it with its own value.
// - the serial presentation enable is a stored setting that decides whether the serial number is reported.
// - every function apart from the serial-port path is controlled only through hid command traffic.
// - every hid report in either direction is exactly 64 bytes long.
// - an exchange is one 64-byte command report from the host followed by one 64-byte response to the host.
// - byte 0 of a command report is the command code, 0x10 being status/set-parameters.
`timescale 1ns/1ns
`include "sshx_consts.vh"
module sshx_settings_store #(
    parameter [63:0] SERIAL_PRESET = 64'h0123_4567_89AB_CDEF
) (
    clk,
    rst_n,
    rxValid,
    rxData,
    rxReady_ff,
    txValid_ff,
    txData_ff,
    txReady,
    loadDone_ff,
    serialEnable_ff,
    serialNumber_ff
);
    // serial preset above is arbitrary; each part gets its own value
    input  wire        clk;
    input  wire        rst_n;
    input  wire        rxValid;
    input  wire [7:0]  rxData;
    output reg         rxReady_ff;
    output reg         txValid_ff;
    output reg  [7:0]  txData_ff;
    input  wire        txReady;
    output reg         loadDone_ff;
    output reg         serialEnable_ff;
    output reg  [63:0] serialNumber_ff;

    localparam [1:0] ST_LOAD = 2'b00;
    localparam [1:0] ST_RECV = 2'b01;
    localparam [1:0] ST_EXEC = 2'b10;
    localparam [1:0] ST_SEND = 2'b11;

    reg  [7:0] nvMem  [0:`SSHX_NV_DEPTH-1];
    reg  [7:0] volMem [0:`SSHX_VOL_DEPTH-1];

    reg  [1:0] state_ff;
    reg  [1:0] nxt_state;
    reg  [4:0] loadAddr_ff;
    reg  [7:0] cmd_ff;
    reg  [7:0] addr_ff;
    reg  [7:0] data_ff;
    reg  [7:0] status_ff;
    reg  [7:0] rdata_ff;
    reg  [7:0] txByte;
    reg  [7:0] txByteNext;
    integer    i;
    integer    j;

    wire       rxTake;
    wire       txTake;
    wire [5:0] rxPos;
    wire [5:0] txPos;
    wire       rxLast;
    wire       txLast;
    wire       nvAddrOk;
    wire       volAddrOk;
    wire       locked;
    wire [4:0] nvIdx;
    wire [3:0] volIdx;

    // nonvolatile content survives reset; this is its factory image
    initial begin
        for (i = 0; i < `SSHX_NV_DEPTH; i = i + 1) begin
            nvMem[i] = `SSHX_BYTE_ZERO;
        end
        nvMem[`SSHX_SER_EN_ADDR] = `SSHX_BYTE_ZERO;
        for (i = 0; i < `SSHX_SER_NUM_LEN; i = i + 1) begin
            nvMem[`SSHX_SER_NUM_ADDR + i] = SERIAL_PRESET[i*8 +: 8];
        end
    end

    // rxReady only rises after the copy, so reports wait until then
    assign rxTake = rxValid & rxReady_ff;
    assign txTake = txValid_ff & txReady;

    sshx_byte_counter #(
        .LEN (64)
    ) u_rxCount (
        .clk   (clk),
        .rst_n (rst_n),
        .step  (rxTake),
        .pos   (rxPos),
        .last  (rxLast)
    );

    sshx_byte_counter #(
        .LEN (64)
    ) u_txCount (
        .clk   (clk),
        .rst_n (rst_n),
        .step  (txTake),
        .pos   (txPos),
        .last  (txLast)
    );

    assign nvIdx     = addr_ff[4:0];
    assign volIdx    = addr_ff[3:0];
    assign nvAddrOk  = (addr_ff < `SSHX_NV_DEPTH);
    assign volAddrOk = (addr_ff < `SSHX_VOL_DEPTH);
    // any nonzero lock byte freezes the nonvolatile copy; writing the
    // open value back is refused as well, so a lock is one-way for the
    // host and only a factory image clears it
    // volatile writes stay allowed while locked: they are lost at reset
    assign locked    = (nvMem[`SSHX_LOCK_ADDR] != `SSHX_LOCK_OPEN);

    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            ST_LOAD: begin
                if (loadAddr_ff == `SSHX_USB_BASE - 5'h01) begin
                    nxt_state = ST_RECV;
                end
            end
            ST_RECV: begin
                if (rxTake && rxLast) begin
                    nxt_state = ST_EXEC;
                end
            end
            ST_EXEC: begin
                nxt_state = ST_SEND;
            end
            ST_SEND: begin
                if (txTake && txLast) begin
                    nxt_state = ST_RECV;
                end
            end
            default: begin
                nxt_state = ST_LOAD;
            end
        endcase
    end

    // response image: only the head bytes carry content, the rest pad
    always @* begin
        case (txPos)
            `SSHX_IDX_CMD:    txByte = cmd_ff;
            `SSHX_IDX_STATUS: txByte = status_ff;
            `SSHX_IDX_RDATA:  txByte = rdata_ff;
            `SSHX_IDX_LOADED: txByte = {7'h00, loadDone_ff};
            `SSHX_IDX_SER_EN: txByte = {7'h00, serialEnable_ff};
            default:          txByte = `SSHX_BYTE_ZERO;
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff    <= ST_LOAD;
            loadAddr_ff <= 5'h00;
            loadDone_ff <= 1'b0;
            rxReady_ff  <= 1'b0;
            txValid_ff  <= 1'b0;
            txData_ff   <= `SSHX_BYTE_ZERO;
            cmd_ff      <= `SSHX_BYTE_ZERO;
            addr_ff     <= `SSHX_BYTE_ZERO;
            data_ff     <= `SSHX_BYTE_ZERO;
            status_ff   <= `SSHX_ST_OK;
            rdata_ff    <= `SSHX_BYTE_ZERO;
        end else begin
            state_ff <= nxt_state;
            if (state_ff == ST_LOAD) begin
                loadAddr_ff <= loadAddr_ff + 5'h01;
            end
            if (state_ff == ST_LOAD && nxt_state == ST_RECV) begin
                loadDone_ff <= 1'b1;
            end
            rxReady_ff <= (nxt_state == ST_RECV);
            if (rxTake) begin
                case (rxPos)
                    `SSHX_IDX_CMD:  cmd_ff  <= rxData;
                    `SSHX_IDX_ADDR: addr_ff <= rxData;
                    `SSHX_IDX_DATA: data_ff <= rxData;
                    default: begin
                    end
                endcase
            end
            if (state_ff == ST_EXEC) begin
                rdata_ff  <= `SSHX_BYTE_ZERO;
                status_ff <= `SSHX_ST_OK;
                case (cmd_ff)
                    `SSHX_CMD_STATUS: begin
                    end
                    `SSHX_CMD_READ_NV: begin
                        if (nvAddrOk) begin
                            rdata_ff <= nvMem[nvIdx];
                        end else begin
                            status_ff <= `SSHX_ST_BAD_ADDR;
                        end
                    end
                    `SSHX_CMD_WRITE_NV: begin
                        if (!nvAddrOk) begin
                            status_ff <= `SSHX_ST_BAD_ADDR;
                        end else if (locked) begin
                            status_ff <= `SSHX_ST_REFUSED;
                        end
                    end
                    `SSHX_CMD_READ_VOL: begin
                        if (volAddrOk) begin
                            rdata_ff <= volMem[volIdx];
                        end else begin
                            status_ff <= `SSHX_ST_BAD_ADDR;
                        end
                    end
                    `SSHX_CMD_WRITE_VOL: begin
                        if (!volAddrOk) begin
                            status_ff <= `SSHX_ST_BAD_ADDR;
                        end
                    end
                    default: begin
                        status_ff <= `SSHX_ST_BAD_CMD;
                    end
                endcase
            end
            if (state_ff == ST_EXEC) begin
                // the tx counter sits at zero here, so this is the echo
                txValid_ff <= 1'b1;
                txData_ff  <= txByte;
            end else if (state_ff == ST_SEND && txTake) begin
                txValid_ff <= !txLast;
                txData_ff  <= txLast ? `SSHX_BYTE_ZERO : txByteNext;
            end
        end
    end

    // byte following the one just taken, so txData stays registered
    // looking one position ahead costs a second decoder but keeps the
    // data output straight from a flip-flop with no added latency
    always @* begin
        case (txPos + 6'h01)
            `SSHX_IDX_STATUS: txByteNext = status_ff;
            `SSHX_IDX_RDATA:  txByteNext = rdata_ff;
            `SSHX_IDX_LOADED: txByteNext = {7'h00, loadDone_ff};
            `SSHX_IDX_SER_EN: txByteNext = {7'h00, serialEnable_ff};
            default:          txByteNext = `SSHX_BYTE_ZERO;
        endcase
    end

    // arrays carry no reset: nonvolatile by nature, volatile filled by copy
    always @(posedge clk) begin
        if (state_ff == ST_LOAD) begin
            // volatile copy ends below the usb area, so it is skipped
            volMem[loadAddr_ff[3:0]] <= nvMem[loadAddr_ff];
        end
        if (state_ff == ST_EXEC && cmd_ff == `SSHX_CMD_WRITE_VOL
                && volAddrOk && loadDone_ff) begin
            volMem[volIdx] <= data_ff;
        end
        if (state_ff == ST_EXEC && cmd_ff == `SSHX_CMD_WRITE_NV
                && nvAddrOk && !locked) begin
            nvMem[nvIdx] <= data_ff;
        end
    end

    // usb settings are used from nonvolatile storage directly
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            serialEnable_ff <= 1'b0;
            serialNumber_ff <= 64'h0000_0000_0000_0000;
        end else begin
            serialEnable_ff <= nvMem[`SSHX_SER_EN_ADDR][0];
            for (j = 0; j < `SSHX_SER_NUM_LEN; j = j + 1) begin
                // a disabled enable hides the number entirely
                serialNumber_ff[j*8 +: 8] <= nvMem[`SSHX_SER_EN_ADDR][0]
                    ? nvMem[`SSHX_SER_NUM_ADDR + j]
                    : `SSHX_BYTE_ZERO;
            end
        end
    end
endmodule // sshx_settings_store

/* File: sshx_settings_store_asserts.sv */
// checker on the report ports of the settings store
`timescale 1ns/1ns
module sshx_settings_store_asserts (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        rxValid,
    input wire logic [7:0]  rxData,
    input wire logic        rxReady_ff,
    input wire logic        txValid_ff,
    input wire logic [7:0]  txData_ff,
    input wire logic        txReady,
    input wire logic        loadDone_ff,
    input wire logic        serialEnable_ff,
    input wire logic [63:0] serialNumber_ff
);
    logic [6:0] rxCnt_ff;
    logic [6:0] txCnt_ff;
    // byte counts restart whenever their side is idle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxCnt_ff <= 7'h00;
            txCnt_ff <= 7'h00;
        end else begin
            rxCnt_ff <= rxReady_ff ? rxCnt_ff + {6'h00, rxValid} : 7'h00;
            txCnt_ff <= txValid_ff ? txCnt_ff + {6'h00, txReady} : 7'h00;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_gate; !loadDone_ff |-> !rxReady_ff; endproperty
    a_gate: assert property (p_gate) else $error("command taken before load");
    property p_done; loadDone_ff |=> loadDone_ff; endproperty
    a_done: assert property (p_done) else $error("load done dropped");
    property p_open; $rose(loadDone_ff) |-> rxReady_ff; endproperty
    a_open: assert property (p_open) else $error("not ready after load");
    property p_half; rxReady_ff |-> !txValid_ff; endproperty
    a_half: assert property (p_half) else $error("rx and tx overlap");
    property p_hold; txValid_ff && !txReady |=> txValid_ff && $stable(txData_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("tx byte lost in stall");
    property p_serOff; !serialEnable_ff |-> serialNumber_ff == 64'h0000_0000_0000_0000;
    endproperty
    a_serOff: assert property (p_serOff) else $error("serial shown while off");
    property p_rxLen; $fell(rxReady_ff) |-> rxCnt_ff == 7'h40; endproperty
    a_rxLen: assert property (p_rxLen) else $error("command not 64 bytes");
    property p_answer; $fell(rxReady_ff) |=> $rose(txValid_ff); endproperty
    a_answer: assert property (p_answer) else $error("response late");
    property p_txLen; $fell(txValid_ff) |-> txCnt_ff == 7'h40 && rxReady_ff;
    endproperty
    a_txLen: assert property (p_txLen) else $error("response not 64 bytes");
    c_load: cover property ($rose(loadDone_ff));
    c_stall: cover property (txValid_ff && !txReady);
    c_serial: cover property ($rose(serialEnable_ff));
endmodule // sshx_settings_store_asserts

bind sshx_settings_store sshx_settings_store_asserts u_sshx_settings_store_asserts (
    .clk(clk), .rst_n(rst_n), .rxValid(rxValid), .rxData(rxData),
    .rxReady_ff(rxReady_ff), .txValid_ff(txValid_ff), .txData_ff(txData_ff),
    .txReady(txReady), .loadDone_ff(loadDone_ff),
    .serialEnable_ff(serialEnable_ff), .serialNumber_ff(serialNumber_ff)
);

/* File: sshx_settings_store_test.sv */
// self-checking bench of the settings store against a reference model
`timescale 1ns/1ns
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) begin errTotal++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module sshx_settings_store_test;
    localparam logic [63:0] PRESET = 64'h1122_3344_5566_7788; // arbitrary
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        rxValid, rxReady_ff, txValid_ff, txReady;
    logic        loadDone_ff, serialEnable_ff;
    logic [7:0]  rxData, txData_ff, a, d;
    logic [63:0] serialNumber_ff, sn;
    logic [7:0]  nv [32];
    logic [7:0]  vol [16];
    integer      seed = 7;
    integer      errTotal = 0;
    integer      checkCount = 0;
    always #20 clk = ~clk;
    sshx_settings_store #(.SERIAL_PRESET(PRESET)) u_sshx_settings_store (
        .clk(clk), .rst_n(rst_n), .rxValid(rxValid), .rxData(rxData),
        .rxReady_ff(rxReady_ff), .txValid_ff(txValid_ff),
        .txData_ff(txData_ff), .txReady(txReady), .loadDone_ff(loadDone_ff),
        .serialEnable_ff(serialEnable_ff), .serialNumber_ff(serialNumber_ff));
    sshx_host_model u_sshx_host_model (
        .clk(clk), .rxValid(rxValid), .rxData(rxData), .rxReady_ff(rxReady_ff),
        .txValid_ff(txValid_ff), .txData_ff(txData_ff), .txReady(txReady));
    task automatic summarize;
        $display("checks %0d mismatches %0d", checkCount, errTotal);
        if (errTotal == 0 && checkCount > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check_serial;
        for (int i = 0; i < 8; i++) sn[8*i +: 8] = nv[17 + i];
        `CHK(serialEnable_ff, nv[16][0])
        `CHK(serialNumber_ff, nv[16][0] ? sn : 64'h0000_0000_0000_0000)
    endtask
    task automatic do_reset;
        @(negedge clk);
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        `CHK({loadDone_ff, rxReady_ff, txValid_ff}, 3'h0)
        rst_n = 1'b1;
        for (int i = 0; i < 16; i++) vol[i] = nv[i];
        for (int i = 0; i < 40 && !loadDone_ff; i++) @(negedge clk);
        `CHK(loadDone_ff, 1'b1)
        check_serial();
    endtask
    task automatic xfer(input logic [7:0] cmd, adr, dat, input bit slow);
        logic [7:0] st = 8'h00;
        logic [7:0] rd = 8'h00;
        bit         isRd = 0;
        case (cmd)
            8'hB0: if (adr < 32) {isRd, rd} = {1'b1, nv[adr]}; else st = 8'h03;
            8'h61: if (adr < 16) {isRd, rd} = {1'b1, vol[adr]}; else st = 8'h03;
            8'h60: if (adr < 16) vol[adr] = dat; else st = 8'h03;
            8'hB1: if (adr > 31) st = 8'h03;
                   else if (nv[15] != 8'h00) st = 8'h01;
                   else nv[adr] = dat;
            8'h10: st = 8'h00;
            default: st = 8'h02;
        endcase
        u_sshx_host_model.send(cmd, adr, dat);
        u_sshx_host_model.fetch(slow);
        `CHK(u_sshx_host_model.resp[0], cmd)
        `CHK(u_sshx_host_model.resp[1], st)
        `CHK(u_sshx_host_model.resp[2], isRd ? rd : 8'h00)
        `CHK(u_sshx_host_model.resp[3], 8'h01)
        `CHK(u_sshx_host_model.resp[4], {7'h00, nv[16][0]})
        for (int i = 5; i < 64; i++) `CHK(u_sshx_host_model.resp[i], 8'h00)
        check_serial();
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        errTotal++;
        summarize();
    end
    initial begin
        for (int i = 0; i < 32; i++) nv[i] = 8'h00;
        for (int i = 0; i < 8; i++) nv[17 + i] = PRESET[8*i +: 8];
        do_reset();
        a = 8'($unsigned($random(seed)) % 16);
        d = 8'($random(seed));
        xfer(8'h10, d, a, 0);
        xfer(8'hB0, 8'h11, 8'h00, 1);
        xfer(8'h60, a, d, 0);
        xfer(8'h61, a, 8'h00, 1);
        xfer(8'h61, 8'h10, 8'h00, 0);
        xfer(8'h55, 8'h00, 8'h00, 1);
        xfer(8'hB1, 8'h10, 8'h01, 0);
        xfer(8'hB1, 8'h11, ~d, 1);
        xfer(8'hB1, 8'h20, 8'h00, 0);
        xfer(8'hB1, 8'h0F, 8'h5A, 1);
        xfer(8'hB1, 8'h10, 8'h00, 0);
        xfer(8'hB1, 8'h0F, 8'h00, 1);
        do_reset();
        xfer(8'h61, 8'h0F, 8'h00, 0);
        xfer(8'hB0, 8'h10, 8'h00, 1);
        summarize();
    end
endmodule // sshx_settings_store_test
